// file: gss_pkg.sv
`default_nettype none
package gss_pkg;
	localparam int STAGE_COUNT = 8;
	localparam int FIFO_DEPTH = 16;
	localparam logic [STAGE_COUNT-1:0] STAGE_RESET = 8'h00;
	localparam logic SYNC_RESET = 1'h0;
	localparam logic CLEAR_IDLE = 1'h1;
	localparam int SYNC_FLOPS = 2;
endpackage
`default_nettype wire

// file: gss_shifter.sv
`timescale 1ns/100ps
`default_nettype none

module gss_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
		$error("fifo depth must be a power of two of at least 2");
	end

	if (WIDTH < 1) begin : g_width_check
		$error("fifo width must be at least 1");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW-1:0] next_wr_ptr;
	logic [AW-1:0] next_rd_ptr;
	logic [AW:0] next_count;
	logic push;
	logic pop;
	logic next_in_ready;
	logic next_out_valid;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count = count;
		if (push) begin
			next_wr_ptr = wr_ptr + 1'h1;
		end
		if (pop) begin
			next_rd_ptr = rd_ptr + 1'h1;
		end
		if (push && !pop) begin
			next_count = count + 1'h1;
		end else if (pop && !push) begin
			next_count = count - 1'h1;
		end
		// flags from the count after this edge, never one cycle stale
		next_in_ready = (next_count != (AW+1)'(DEPTH));
		next_out_valid = (next_count != '0);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready <= 1'h0;
			out_valid <= 1'h0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			in_ready <= next_in_ready;
			out_valid <= next_out_valid;
		end
	end

	// storage has no reset, only written on push
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// count, pointers and flags agree, so no word is lost or read twice
	count_bound_a: assert property (@(posedge clk) disable iff (!arst_n)
		count <= (AW+1)'(DEPTH))
		else $error("queue count above its depth");
	ptr_gap_a: assert property (@(posedge clk) disable iff (!arst_n)
		AW'(wr_ptr - rd_ptr) == count[AW-1:0])
		else $error("queue pointers disagree with its count");
	room_flag_a: assert property (@(posedge clk) disable iff (!arst_n)
		$past(arst_n) |-> in_ready == (count != (AW+1)'(DEPTH)))
		else $error("queue room flag off by one");
	fill_flag_a: assert property (@(posedge clk) disable iff (!arst_n)
		out_valid == (count != '0))
		else $error("queue fill flag off by one");
endmodule

module gss_shifter #(
	parameter int STAGES = gss_pkg::STAGE_COUNT,
	parameter int DEPTH = gss_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic gate_a,
	input wire logic gate_b,
	input wire logic shift_clk,
	input wire logic clear_n,
	output logic [gss_pkg::STAGE_COUNT-1:0] q,
	output logic cascade_out,
	output logic [gss_pkg::STAGE_COUNT-1:0] word_data,
	output logic word_valid,
	input wire logic word_ready,
	output logic word_room
);
	import gss_pkg::*;

	if (STAGES != STAGE_COUNT) begin : g_stage_check
		$error("stage count must match the package width");
	end

	if (SYNC_FLOPS < 2) begin : g_sync_check
		$error("pin synchroniser needs at least two flops");
	end

	logic [SYNC_FLOPS-1:0] a_sync;
	logic [SYNC_FLOPS-1:0] b_sync;
	logic [SYNC_FLOPS-1:0] c_sync;
	logic c_last;
	logic [SYNC_FLOPS-1:0] next_a_sync;
	logic [SYNC_FLOPS-1:0] next_b_sync;
	logic [SYNC_FLOPS-1:0] next_c_sync;
	logic next_c_last;
	logic shift_evt;
	logic serial_bit;
	logic stage_rst_n;
	logic [STAGE_COUNT-1:0] next_q;
	logic next_cascade;
	logic push_valid;
	logic next_push_valid;
	logic [STAGE_COUNT-1:0] push_data;
	logic fifo_in_ready;
	logic [STAGE_COUNT-1:0] fifo_out_data;
	logic fifo_out_valid;
	logic [STAGE_COUNT-1:0] next_word_data;

	// gate and serial clock pins pass two flops before any logic reads them
	always_comb begin
		next_a_sync = {a_sync[SYNC_FLOPS-2:0], gate_a};
		next_b_sync = {b_sync[SYNC_FLOPS-2:0], gate_b};
		next_c_sync = {c_sync[SYNC_FLOPS-2:0], shift_clk};
		next_c_last = c_sync[SYNC_FLOPS-1];
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			a_sync <= '0;
			b_sync <= '0;
			c_sync <= '0;
			c_last <= SYNC_RESET;
		end else begin
			a_sync <= next_a_sync;
			b_sync <= next_b_sync;
			c_sync <= next_c_sync;
			c_last <= next_c_last;
		end
	end

	assign shift_evt = c_sync[SYNC_FLOPS-1] && !c_last;
	assign serial_bit = a_sync[SYNC_FLOPS-1] && b_sync[SYNC_FLOPS-1];

	// clear pin acts on the stages directly, like the system reset
	assign stage_rst_n = arst_n && clear_n;

	always_comb begin
		next_q = q;
		next_cascade = cascade_out;
		if (shift_evt) begin
			// gates are looked at only here, on the edge
			next_q = {q[STAGE_COUNT-2:0], serial_bit};
			next_cascade = q[STAGE_COUNT-2];
		end
	end

	always_ff @(posedge clk or negedge stage_rst_n) begin
		if (!stage_rst_n) begin
			q <= STAGE_RESET;
			cascade_out <= STAGE_RESET[STAGE_COUNT-1];
		end else begin
			q <= next_q;
			cascade_out <= next_cascade;
		end
	end

	// each new parallel word is queued for the reader while the fifo has room; words shifted while it is full are dropped
	always_comb begin
		next_push_valid = shift_evt;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			push_valid <= 1'h0;
		end else begin
			push_valid <= next_push_valid;
		end
	end

	assign push_data = q;

	gss_fifo #(
		.WIDTH(STAGE_COUNT),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk(clk),
		.arst_n(arst_n),
		.in_data(push_data),
		.in_valid(push_valid),
		.in_ready(fifo_in_ready),
		.out_data(fifo_out_data),
		.out_valid(fifo_out_valid),
		.out_ready(word_ready)
	);

	// outputs from flops: word_data is the fifo head one cycle late, in_ready is a flop
	assign word_valid = fifo_out_valid;
	assign word_room = fifo_in_ready;

	// registered head: a word shows here after the edge that pops it
	always_comb begin
		next_word_data = fifo_out_data;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			word_data <= '0;
		end else begin
			word_data <= next_word_data;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// stage checks; a clear seen at either of two edges makes the shift and hold checks vacuous, the clear checks fire on it
	word_shift_a: assert property (
		clear_n && $past(clear_n) && $past(shift_evt)
		|-> q == {$past(q[STAGE_COUNT-2:0]), $past(serial_bit)})
		else $error("eight stages did not take the shifted word");
	first_load_a: assert property (
		clear_n && $past(clear_n) && $past(shift_evt)
		|-> q[0] == $past(serial_bit))
		else $error("first stage did not load the gated bit");
	hold_idle_a: assert property (
		clear_n && $past(clear_n) && !$past(shift_evt) |-> $stable(q))
		else $error("stages moved without a rising serial clock");
	fall_ignored_a: assert property (
		clear_n && $past(clear_n) && $past(c_last)
		&& !$past(c_sync[SYNC_FLOPS-1]) |-> $stable(q))
		else $error("stages moved on a falling serial clock");
	shift_chain_a: assert property (
		clear_n && $past(clear_n) && $past(shift_evt)
		|-> q[STAGE_COUNT-1:1] == $past(q[STAGE_COUNT-2:0]))
		else $error("stages did not advance by one");
	clear_force_a: assert property (!clear_n |-> q == '0)
		else $error("clear did not force stages low");
	clear_cascade_a: assert property (!clear_n |-> !cascade_out)
		else $error("clear did not force cascade output low");
	gate_sample_a: assert property (
		clear_n && $past(clear_n, 4) && $rose(shift_evt)
		|=> q[0] == ($past(gate_a, 3) && $past(gate_b, 3)))
		else $error("gate value not taken at the edge");
	cascade_out_a: assert property (cascade_out == q[STAGE_COUNT-1])
		else $error("cascade output differs from last stage");
	queue_word_a: assert property (
		clear_n && $past(clear_n) && shift_evt
		|=> push_valid
		&& push_data == {$past(q[STAGE_COUNT-2:0]), $past(serial_bit)})
		else $error("shifted word not offered to the queue");

	// queue towards the reader
	word_offer_a: assert property (push_valid && word_room |=> word_valid)
		else $error("pushed word not offered to the reader");
	word_stand_a: assert property (word_valid && !word_ready |=> word_valid)
		else $error("word withdrawn before it was taken");
	full_drop_a: assert property (!word_room && push_valid && !word_ready
		|=> !word_room)
		else $error("full queue took a word");

	shift_one_c: cover property (shift_evt ##1 q[0]);
	clear_hit_c: cover property (q != '0 ##1 !clear_n);
	fifo_full_c: cover property (!word_room);
	word_take_c: cover property (word_valid && word_ready);
	word_drop_c: cover property (push_valid && !word_room);
endmodule

`default_nettype wire

// file: gss_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module gss_ctrl_model (
	input wire logic clk,
	output logic gate_a,
	output logic gate_b,
	output logic shift_clk,
	output logic clear_n
);
	initial begin
		gate_a = 1'h0;
		gate_b = 1'h0;
		shift_clk = 1'h0;
		clear_n = 1'h1;
	end
	// one rising edge: 4 clk high, 4 clk low
	task automatic shift_bit(input logic a, input logic b);
		@(posedge clk);
		#1;
		gate_a = a;
		gate_b = b;
		shift_clk = 1'h1;
		repeat (3) @(posedge clk);
		#1;
		// hold time over: gates change between edges
		gate_a = ~a;
		gate_b = ~b;
		@(posedge clk);
		#1;
		shift_clk = 1'h0;
		repeat (4) @(posedge clk);
	endtask
	task automatic set_clear(input logic lvl);
		@(posedge clk);
		#1;
		clear_n = lvl;
	endtask
endmodule
`default_nettype wire

// file: gss_shifter_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
	fail_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module gss_shifter_test;
	import gss_pkg::*;
	logic clk = 1'h0;
	logic arst_n = 1'h0;
	logic word_ready = 1'h1;
	wire logic gate_a, gate_b, shift_clk, clear_n, cascade_out;
	wire logic word_valid, word_room;
	wire logic [STAGE_COUNT-1:0] q, word_data;
	logic [STAGE_COUNT-1:0] exp_q = STAGE_RESET;
	int fail_count = 0;
	int compares = 0;
	int cycles = 0;
	gss_ctrl_model ctrl_u (.clk(clk), .gate_a(gate_a), .gate_b(gate_b),
		.shift_clk(shift_clk), .clear_n(clear_n));
	gss_shifter dut_u (.clk(clk), .arst_n(arst_n), .gate_a(gate_a),
		.gate_b(gate_b), .shift_clk(shift_clk), .clear_n(clear_n), .q(q),
		.cascade_out(cascade_out), .word_data(word_data),
		.word_valid(word_valid), .word_ready(word_ready),
		.word_room(word_room));
	initial begin
		forever #2.5 clk = ~clk;
	end
	task automatic step(input logic a, input logic b);
		ctrl_u.shift_bit(a, b);
		exp_q = {exp_q[STAGE_COUNT-2:0], a & b};
		`CHK("q", exp_q, q)
		`CHK("cas", exp_q[STAGE_COUNT-1], cascade_out)
	endtask
	task automatic shift_test();
		logic [11:0] pa = 12'hb6c;
		logic [11:0] pb = 12'hdb6;
		`CHK("rst q", STAGE_RESET, q)
		`CHK("rst cas", 1'h0, cascade_out)
		for (int i = 0; i < 12; i++) begin
			step(pa[i], pb[i]);
		end
	endtask
	task automatic clear_test();
		ctrl_u.set_clear(1'h0);
		#1;
		`CHK("clr q", STAGE_RESET, q)
		`CHK("clr cas", 1'h0, cascade_out)
		ctrl_u.shift_bit(1'h1, 1'h1);
		`CHK("held q", STAGE_RESET, q)
		ctrl_u.set_clear(1'h1);
		exp_q = STAGE_RESET;
		step(1'h1, 1'h1);
	endtask
	task automatic fifo_test();
		int n = 0;
		logic took = 1'h0;
		logic [STAGE_COUNT-1:0] exp_w = exp_q;
		#1;
		word_ready = 1'h0;
		repeat (FIFO_DEPTH + 2) step(1'h1, 1'h0);
		`CHK("room", 1'h0, word_room)
		@(posedge clk);
		#1;
		word_ready = 1'h1;
		repeat (40) begin
			@(negedge clk);
			if (took) `CHK("word", exp_w, word_data)
			took = (word_valid === 1'h1);
			if (took) begin
				n++;
				exp_w = {exp_w[STAGE_COUNT-2:0], 1'h0};
			end
		end
		`CHK("words", FIFO_DEPTH, n)
		`CHK("empty", 1'h0, word_valid)
	endtask
	task automatic conclude();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		#1;
		arst_n = 1'h1;
		shift_test();
		clear_test();
		fifo_test();
		conclude();
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			conclude();
		end
	end
endmodule
`default_nettype wire
